/* File: logic/hcp_regs.svh */
`ifndef HCP_REGS_SVH
`define HCP_REGS_SVH
`define HCP_ADDR_W 32
`define HCP_DATA_W 32
`define HCP_WORD_W 64
`define HCP_ENTRY_W 64
`define HCP_HBUF_DEPTH 8
`define HCP_HBUF_AW 3
`define HCP_EQ_DEPTH 25
`define HCP_EQ_AW 5
`define HCP_EQ_LAST 5'h18
`define HCP_CNT_W 6
`define HCP_SWAP_NONE 2'h0
`define HCP_SWAP_WORD 2'h1
`define HCP_SWAP_DWORD 2'h2
`define HCP_ENT_CMD 1'h1
`define HCP_WORDS_PER_OP 4'h4
`endif

/* File: logic/hcp_pkg.sv */
package hcp_pkg;
  typedef enum logic [2:0] {
    HCP_IDLE = 3'h1,
    HCP_LOAD = 3'h2,
    HCP_RUN = 3'h4
  } hcp_eng_st_t;
endpackage : hcp_pkg

/* File: logic/hcp_fifo.sv */
`timescale 1ns/1ps
`include "hcp_regs.svh"
module hcp_fifo #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int CW = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [`HCP_ENTRY_W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [`HCP_ENTRY_W-1:0] o_data,
  output logic [CW-1:0] o_count
);
  logic [`HCP_ENTRY_W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [CW-1:0] cnt_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction : inc_ptr

  assign o_ready = (cnt_ff != CW'(DEPTH));
  assign o_valid = (cnt_ff != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rptr_ff];
  assign o_count = cnt_ff;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_ff] <= i_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= inc_ptr(wptr_ff);
      end
      if (pop) begin
        rptr_ff <= inc_ptr(rptr_ff);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + CW'(1);
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  no_overflow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cnt_ff <= CW'(DEPTH)) else $error("fifo count above depth");
  count_track_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (push && !pop) |=> cnt_ff == $past(cnt_ff) + CW'(1))
    else $error("fifo count did not rise on push");
endmodule : hcp_fifo

/* File: logic/hcp_skid.sv */
`timescale 1ns/1ps
`include "hcp_regs.svh"
module hcp_skid (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [`HCP_WORD_W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [`HCP_WORD_W-1:0] o_data
);
  // Two entries: ready is registered-friendly and a stall loses nothing
  logic [`HCP_WORD_W-1:0] buf_ff [2];
  logic wsel_ff;
  logic rsel_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  assign o_ready = (cnt_ff != 2'h2);
  assign o_valid = (cnt_ff != 2'h0);
  assign o_data = buf_ff[rsel_ff];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      buf_ff[wsel_ff] <= i_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wsel_ff <= 1'b0;
      rsel_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wsel_ff <= !wsel_ff;
      end
      if (pop) begin
        rsel_ff <= !rsel_ff;
      end
      cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
    end
  end

  skid_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_valid && !i_ready) |=> (o_valid && $stable(o_data)))
    else $error("output word changed while stalled");
endmodule : hcp_skid

/* File: logic/hcp_cmd_path.sv */
`timescale 1ns/1ps
`include "hcp_regs.svh"
module hcp_cmd_path #(
  parameter logic [`HCP_ADDR_W-1:0] BASE = 32'hF000_0000,
  parameter logic [`HCP_ADDR_W-1:0] MASK = 32'hFFFF_F000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic o_wr_hit,
  input wire logic [`HCP_ADDR_W-1:0] i_wr_addr,
  input wire logic [`HCP_DATA_W-1:0] i_wr_data,
  input wire logic i_wr_cmd,
  input wire logic [1:0] i_swap_mode,
  input wire logic i_op_done,
  output logic o_op_start,
  output logic [`HCP_ENTRY_W-1:0] o_work_reg [4],
  output logic o_busy,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [`HCP_WORD_W-1:0] o_word,
  output logic [`HCP_CNT_W-1:0] o_eq_count
);
  logic hit;
  logic [`HCP_DATA_W-1:0] swapped;
  logic [`HCP_ENTRY_W-1:0] hb_in;
  logic hb_ready;
  logic hb_valid;
  logic [`HCP_ENTRY_W-1:0] hb_data;
  logic eq_ready;
  logic eq_valid;
  logic eq_pop;
  logic [`HCP_ENTRY_W-1:0] eq_data;
  logic [`HCP_CNT_W-1:0] eq_cnt;
  logic [3:0] hb_cnt;
  hcp_pkg::hcp_eng_st_t st_ff;
  hcp_pkg::hcp_eng_st_t nxt_st;
  logic [1:0] ld_idx_ff;
  logic [`HCP_ENTRY_W-1:0] work_ff [4];
  logic [`HCP_WORD_W-1:0] run_word_ff;
  logic sk_ready;
  logic sk_valid_in;
  logic start_ff;

  function automatic logic [31:0] swap_bytes(input logic [31:0] d,
                                             input logic [1:0] m);
    unique case (m)
      `HCP_SWAP_WORD: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      `HCP_SWAP_DWORD: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: return d;
    endcase
  endfunction : swap_bytes

  assign hit = ((i_wr_addr & MASK) == (BASE & MASK));
  assign o_wr_hit = hit;
  assign swapped = swap_bytes(i_wr_data, i_swap_mode);
  // entry carries kind, address bits 30:0 and data
  assign hb_in = {i_wr_cmd, i_wr_addr[`HCP_ADDR_W-2:0], swapped};
  assign o_wr_ready = hb_ready || !hit;

  hcp_fifo #(.DEPTH(`HCP_HBUF_DEPTH), .AW(`HCP_HBUF_AW), .CW(4)) u_hbuf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_wr_valid && hit),
    .o_ready(hb_ready),
    .i_data(hb_in),
    .o_valid(hb_valid),
    .i_ready(eq_ready),
    .o_data(hb_data),
    .o_count(hb_cnt)
  );

  // 25-entry engine queue frees host buffer
  hcp_fifo #(.DEPTH(`HCP_EQ_DEPTH), .AW(`HCP_EQ_AW), .CW(`HCP_CNT_W)) u_eq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(hb_valid),
    .o_ready(eq_ready),
    .i_data(hb_data),
    .o_valid(eq_valid),
    .i_ready(eq_pop),
    .o_data(eq_data),
    .o_count(eq_cnt)
  );
  assign o_eq_count = eq_cnt;

  assign eq_pop = eq_valid && (st_ff == hcp_pkg::HCP_LOAD);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      hcp_pkg::HCP_IDLE: begin
        if (eq_valid) begin
          nxt_st = hcp_pkg::HCP_LOAD;
        end
      end
      hcp_pkg::HCP_LOAD: begin
        if (eq_pop && ld_idx_ff == 2'(`HCP_WORDS_PER_OP - 1)) begin
          nxt_st = hcp_pkg::HCP_RUN;
        end
      end
      hcp_pkg::HCP_RUN: begin
        if (i_op_done) begin
          nxt_st = hcp_pkg::HCP_IDLE;
        end
      end
      default: nxt_st = hcp_pkg::HCP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= hcp_pkg::HCP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ld_idx_ff <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        work_ff[i] <= '0;
      end
    end else if (eq_pop) begin
      work_ff[ld_idx_ff] <= eq_data;
      ld_idx_ff <= ld_idx_ff + 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= (st_ff == hcp_pkg::HCP_LOAD) &&
                  (nxt_st == hcp_pkg::HCP_RUN);
    end
  end
  assign o_op_start = start_ff;
  assign o_work_reg = work_ff;
  assign o_busy = (st_ff != hcp_pkg::HCP_IDLE);

  // one 64-bit word per cycle while running
  assign sk_valid_in = (st_ff == hcp_pkg::HCP_RUN);
  // Seed on entry to RUN so the first pushed word is work 0, not stale
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_word_ff <= '0;
    end else if ((st_ff == hcp_pkg::HCP_LOAD) &&
                 (nxt_st == hcp_pkg::HCP_RUN)) begin
      run_word_ff <= work_ff[0];
    end else if (sk_valid_in && sk_ready) begin
      run_word_ff <= run_word_ff + work_ff[1];
    end
  end

  // Output stall holds engine words without loss
  hcp_skid u_skid (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(sk_valid_in),
    .o_ready(sk_ready),
    .i_data(run_word_ff),
    .o_valid(o_word_valid),
    .i_ready(i_word_ready),
    .o_data(o_word)
  );

  miss_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr_valid && !hit) |-> o_wr_ready)
    else $error("missed address stalled host");
  swap_dword_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_swap_mode == `HCP_SWAP_DWORD) |-> swapped[7:0] == i_wr_data[31:24])
    else $error("dword swap wrong");
  hbuf_full_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (hb_cnt == 4'h8) |-> !o_wr_ready || !hit)
    else $error("write taken into full host buffer");
  eq_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    eq_cnt <= 6'(`HCP_EQ_DEPTH)) else $error("engine queue overfull");
  no_load_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_ff == hcp_pkg::HCP_RUN) |-> !eq_pop)
    else $error("queue popped mid operation");
  start_after_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_op_start |-> $past(st_ff == hcp_pkg::HCP_LOAD) &&
    st_ff == hcp_pkg::HCP_RUN) else $error("start without load");
  move_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (hb_valid && eq_ready) |=> hb_cnt != 4'h8 || $past(hb_cnt) == 4'h8)
    else $error("host buffer not freed");
  word_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (sk_valid_in && sk_ready) [*2] |-> $changed(run_word_ff) ||
    work_ff[1] == '0) else $error("engine word rate lost");
  full_burst_c: cover property (@(posedge i_clk) disable iff (i_rst)
    hb_cnt == 4'h8);
  eq_full_c: cover property (@(posedge i_clk) disable iff (i_rst)
    eq_cnt == 6'(`HCP_EQ_DEPTH));
  op_cycle_c: cover property (@(posedge i_clk) disable iff (i_rst)
    o_op_start ##[1:50] i_op_done);
endmodule : hcp_cmd_path

/* File: verification/hcp_eng_model.sv */
`timescale 1ns/1ps
module hcp_eng_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hold,
  input wire logic i_start,
  output logic o_done,
  output logic o_word_ready
);
  int wait_q;
  always @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_word_ready <= 1'b0;
      wait_q <= -1;
    end else begin
      // Random stalls so the output buffer sees back pressure
      o_word_ready <= ($urandom % 4) != 0;
      o_done <= 1'b0;
      if (i_start) begin
        wait_q <= 2 + $urandom % 6;
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end else if (wait_q == 0 && !i_hold) begin
        o_done <= 1'b1;
        wait_q <= -1;
      end
    end
  end
endmodule : hcp_eng_model

/* File: verification/host_to_2d_command_path_tb.sv */
`timescale 1ns/1ps
`include "hcp_regs.svh"
module host_to_2d_command_path_tb;
  logic i_clk, i_rst, i_wr_valid, i_wr_cmd, i_op_done, i_word_ready;
  logic o_wr_ready, o_wr_hit, o_op_start, o_busy, o_word_valid, hold;
  logic [`HCP_ADDR_W-1:0] i_wr_addr;
  logic [`HCP_DATA_W-1:0] i_wr_data;
  logic [1:0] i_swap_mode;
  logic [`HCP_ENTRY_W-1:0] o_work_reg [4];
  logic [`HCP_WORD_W-1:0] o_word;
  logic [`HCP_CNT_W-1:0] o_eq_count;
  logic [63:0] exp_q [$];
  logic [63:0] base_q [$];
  logic [63:0] step_q [$];
  logic [63:0] ev, cur_b, cur_s;
  int fail_count, tests_run, pend, waits, have;
  localparam logic [31:0] BASE = 32'hF000_0000;
  localparam logic [31:0] MASK = 32'hFFFF_F000;

  hcp_cmd_path u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready),
    .o_wr_hit(o_wr_hit), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_wr_cmd(i_wr_cmd), .i_swap_mode(i_swap_mode),
    .i_op_done(i_op_done), .o_op_start(o_op_start),
    .o_work_reg(o_work_reg), .o_busy(o_busy),
    .o_word_valid(o_word_valid), .i_word_ready(i_word_ready),
    .o_word(o_word), .o_eq_count(o_eq_count));
  hcp_eng_model u_eng (.i_clk(i_clk), .i_rst(i_rst), .i_hold(hold),
    .i_start(o_op_start), .o_done(i_op_done),
    .o_word_ready(i_word_ready));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic check(input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  function automatic logic [31:0] swp(input logic [31:0] d,
                                      input logic [1:0] m);
    if (m == `HCP_SWAP_WORD) return {d[23:16], d[31:24], d[7:0], d[15:8]};
    if (m == `HCP_SWAP_DWORD) return {d[7:0], d[15:8], d[23:16], d[31:24]};
    return d;
  endfunction : swp

  // Leaves valid high; the caller lowers it after the burst
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic c, input logic [1:0] m);
    logic hit;
    int n;
    hit = (a & MASK) == (BASE & MASK);
    i_wr_valid = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
    i_wr_cmd = c;
    i_swap_mode = m;
    #1 check(64'(hit), 64'(o_wr_hit));
    for (n = 0; n < 2000; n++) begin
      @(posedge i_clk);
      if (o_wr_ready === 1'b1 || !hit) break;
    end
    if (n == 2000) begin
      check(0, 1);
      close_out();
    end
    waits += n;
    if (hit) exp_q.push_back({c, a[30:0], swp(d, m)});
    @(negedge i_clk);
  endtask : wr

  task automatic drain;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge i_clk);
      if (exp_q.size() == 0 && o_busy === 1'b0) break;
    end
    if (n == 3000) begin
      check(0, 1);
      close_out();
    end
  endtask : drain

  task automatic burst(input int cnt);
    waits = 0;
    for (int i = 0; i < cnt; i++)
      wr(BASE | ($urandom % 4096), $urandom, i % 4 == 0, 2'(i % 3));
  endtask : burst

  always @(negedge i_clk) begin
    if (o_op_start === 1'b1) begin
      check(1, 64'(pend == 0));
      check(1, 64'(o_busy));
      pend = 1;
      for (int k = 0; k < 4; k++) begin
        if (exp_q.size() == 0) check(0, 1);
        else begin
          ev = exp_q.pop_front();
          if (k == 0) base_q.push_back(ev);
          if (k == 1) step_q.push_back(ev);
          check(ev, o_work_reg[k]);
        end
      end
    end
    if (i_op_done === 1'b1) pend = 0;
  end

  // Words of one op run base, base+step, ...; a new op starts at its base
  always @(negedge i_clk) begin
    #1;
    if (o_word_valid === 1'b1 && i_word_ready === 1'b1) begin
      if (!(have != 0 && o_word === cur_b) && base_q.size() > 0) begin
        cur_b = base_q.pop_front();
        cur_s = step_q.pop_front();
        have = 1;
      end
      check(cur_b, o_word);
      cur_b = cur_b + cur_s;
    end
  end

  initial begin
    i_rst = 1'b1;
    i_wr_valid = 1'b0;
    i_wr_addr = '0;
    i_wr_data = '0;
    i_wr_cmd = 1'b0;
    i_swap_mode = 2'h0;
    hold = 1'b0;
    fail_count = 0;
    tests_run = 0;
    pend = 0;
    have = 0;
    cur_b = '0;
    cur_s = '0;
    void'($urandom(46287));
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    // Misses on bit 12 and bit 31 must not enter the queues
    wr(32'hF000_1000, 32'h1234_5678, 1'b1, 2'h0);
    wr(32'h7000_0000, 32'h9ABC_DEF0, 1'b1, 2'h0);
    $display("test miss done");
    burst(12);
    check(0, 64'(waits));
    i_wr_valid = 1'b0;
    drain();
    $display("test swap burst done");
    hold = 1'b1;
    // Four in working regs, 25 in engine queue, 8 in host buffer
    burst(37);
    check(0, 64'(waits));
    i_wr_valid = 1'b0;
    repeat (4) @(negedge i_clk);
    check(0, 64'(o_wr_ready));
    check(`HCP_EQ_DEPTH, 64'(o_eq_count));
    check(33, 64'(exp_q.size()));
    hold = 1'b0;
    burst(3);
    i_wr_valid = 1'b0;
    drain();
    check(0, 64'(o_eq_count));
    $display("test fill done");
    close_out();
  end
endmodule : host_to_2d_command_path_tb
